// file: dv/psr_checker_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Pin-level watch; pin to output takes 3 or 4 cycles
module psr_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_permit1,
  input wire logic i_stroke_end,
  input wire logic [1:0] i_mode,
  input wire logic i_stroke_en,
  input wire logic o_release,
  input wire logic o_restart_req,
  input wire logic o_permit1_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_held_stop; !i_start [*5]; endsequence
  a_perm_drop: assert property (!i_permit1 |-> ##3 !o_release && o_permit1_n)
    else $error("permit low");
  a_perm_inv: assert property (i_permit1 |-> ##3 !o_permit1_n) else $error("inv");
  a_start_go: assert property ($rose(o_release) |-> $past(i_start, 3))
    else $error("go");
  a_start_stop: assert property (s_held_stop |-> !o_release) else $error("stop");
  a_top_stop: assert property (i_stroke_en && $rose(i_stroke_end) |-> ##[3:5] !o_release)
    else $error("top");
  a_req_block: assert property (o_restart_req |-> !o_release) else $error("req");
  a_mode_none: assert property (i_mode == 2'h1 |-> !o_restart_req) else $error("mode");
  a_power_lock: assert property ($fell(i_rst) && i_mode != 2'h1 |-> ##[1:6] o_restart_req)
    else $error("power");
endmodule // psr_checker
bind psr_top psr_checker chk_u (.*);
`default_nettype wire

// file: dv/psr_press_model.sv
`timescale 1ns/10ps
`default_nettype none
// Operator restart button; idles low so every press is low-high-low
module psr_press_model (
  input wire logic i_clk,
  input wire logic i_hold,
  output logic o_restart
);
  // Button follows the bench's hold request on the falling edge
  always @(negedge i_clk) begin
    o_restart <= i_hold;
  end
  initial o_restart = 1'b0;
endmodule // psr_press_model
`default_nettype wire

// file: dv/psr_top_test.sv
`timescale 1ns/10ps
`default_nettype none
// Each mode in turn, then the permit corners
module psr_top_test;
  logic clk = 1'b0, rst = 1'b1, st = 1'b0, p1 = 1'b1, p2 = 1'b1, se = 1'b0, p2e = 1'b0;
  logic sen = 1'b0, lp = 1'b0, hd = 1'b0, rs, rel, req, p1n;
  logic [1:0] md = 2'h1;
  logic [3:0] rows [4] = '{4'h4, 4'hB, 4'hF, 4'h2};
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  always #2 clk = ~clk;
  psr_top #(.CYCLES_PER_MS(10)) dut_u (.i_clk(clk), .i_rst(rst), .i_start(st), .i_permit1(p1),
    .i_permit2(p2), .i_stroke_end(se), .i_restart(rs), .i_mode(md), .i_permit2_en(p2e),
    .i_stroke_en(sen), .i_long_pulse(lp), .o_release(rel), .o_restart_req(req),
    .o_permit1_n(p1n));
  psr_press_model pm_u (.i_clk(clk), .i_hold(hd), .o_restart(rs));
  task w(input int n); repeat (n) @(negedge clk); endtask
  task chk(input string nm, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s exp %b seen %b", nm, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Mode is unsynced, so it only changes under reset
  task rsd(input logic [1:0] m); md = m; rst = 1'b1; w(3); rst = 1'b0; w(5); endtask
  task pls(input int n); hd = 1'b1; w(n); hd = 1'b0; w(8); endtask
  task run(input logic v); st = v; w(6); endtask
  // Run needs about 9300 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      rsd(rows[i][3:2]);
      chk("req", rows[i][1], req);
      pls(1100);
      chk("req", 1'b0, req);
      run(1'b1);
      chk("rel", 1'b1, rel);
      run(1'b0);
      chk("req", rows[i][0], req);
    end
    // 110 ms is short of the long minimum
    lp = 1'b1; sen = 1'b1; rsd(2'h0);
    pls(1100);
    chk("req", 1'b1, req);
    pls(3600);
    run(1'b1);
    se = 1'b1; w(6);
    chk("req", 1'b1, req);
    chk("rel", 1'b0, rel);
    se = 1'b0; st = 1'b0; sen = 1'b0; p2e = 1'b1; rsd(2'h1);
    p2 = 1'b0; run(1'b1);
    chk("rel", 1'b0, rel);
    run(1'b0); p2 = 1'b1; run(1'b1); p2 = 1'b0; se = 1'b1; w(6);
    chk("rel", 1'b1, rel);
    chk("rel", 1'b1, rel);
    p1 = 1'b0; w(4);
    chk("inv", 1'b1, p1n);
    chk("rel", 1'b0, rel);
    // Mid-run reset forces the inverted permit back to its reset level
    p1 = 1'b1; w(5);
    chk("inv", 1'b0, p1n);
    rst = 1'b1; w(2);
    chk("inv", 1'b1, p1n);
    chk("req", 1'b0, req);
    rst = 1'b0; w(5);
    chk("inv", 1'b0, p1n);
    stop_test();
  end
endmodule // psr_top_test
`default_nettype wire

// file: logic/psr_ms_tick.v
`timescale 1ns/10ps
`default_nettype none
// Millisecond enable pulse from the system clock
module psr_ms_tick #(
  parameter CYCLES_PER_MS = 250000
) (
  input wire i_clk,
  input wire i_rst,
  output reg o_tick
);
  reg [31:0] cnt_ff;
  // Free running divider; one-cycle tick at wrap
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else if (cnt_ff >= CYCLES_PER_MS - 1) begin
      cnt_ff <= 32'h0000_0000;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end
endmodule // psr_ms_tick
`default_nettype wire

// file: logic/psr_regs.vh
// Notes on behaviour
// RQ1: Release drops at once when permit one low
// RQ2: Inverted permit output mirrors permit one
// RQ3: Start rising edge starts, falling edge stops
// RQ4: Permit two checked only before release rises
// RQ5: Stroke end rising edge drops release
// RQ6: Restart required high while interlock active
// RQ7: Valid restart sequence clears the interlock
// RQ8: Four interlock modes: none, always, start, stroke
// RQ9: Permit two switch; off means input ignored
// RQ10: Single stroke switch; off ignores stroke end
// RQ11: Restart low-high-low, high at least minimum time
// RQ12: Mode two rearms on every stop
// RQ13: Mode three rearms on start or permit stops
// RQ14: Mode four rearms on stroke or permit stops
// RQ15: No release while restart required; millisecond counter
// RQ16: Edges found by comparing current and previous sample
`ifndef PSR_REGS_VH
`define PSR_REGS_VH
`define PSR_MODE_NONE 2'h1
`define PSR_MODE_ALWAYS 2'h2
`define PSR_MODE_START 2'h3
`define PSR_MODE_STROKE 2'h0
`define PSR_CLK_HZ 250000000
`define PSR_MS_PER_S 1000
`define PSR_MIN_PULSE_SHORT_MS 100
`define PSR_MIN_PULSE_LONG_MS 350
`define PSR_SYNC_SETTLE 2'h3
`endif

// file: logic/psr_top.v
`timescale 1ns/10ps
`default_nettype none
`include "psr_regs.vh"
// Press setup release gate
module psr_top #(
  parameter CYCLES_PER_MS = `PSR_CLK_HZ / `PSR_MS_PER_S
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_start,
  input wire i_permit1,
  input wire i_permit2,
  input wire i_stroke_end,
  input wire i_restart,
  input wire [1:0] i_mode,
  input wire i_permit2_en,
  input wire i_stroke_en,
  input wire i_long_pulse,
  output reg o_release,
  output reg o_restart_req,
  output reg o_permit1_n
);
  // Bit positions of the pins inside the synchroniser vectors
  localparam PIN_START = 0;
  localparam PIN_PERM1 = 1;
  localparam PIN_PERM2 = 2;
  localparam PIN_STROKE = 3;
  localparam PIN_RESTART = 4;
  localparam NPINS = 5;

  // Restart pulse width counter; 9 bits hold the long minimum
  localparam PULSE_W = 9;
  localparam [PULSE_W-1:0] PULSE_MAX = 9'h1ff;
  localparam [PULSE_W-1:0] PULSE_ONE = 9'h001;
  localparam [PULSE_W-1:0] PULSE_ZERO = 9'h000;

  // Release states, one-hot
  localparam [1:0] REL_IDLE = 2'h1;
  localparam [1:0] REL_RUN = 2'h2;

  // Restart sequence states, one-hot
  // Waiting for low first refuses a button already held at power up
  localparam [2:0] RS_WAIT_LOW = 3'h1;
  localparam [2:0] RS_LOW = 3'h2;
  localparam [2:0] RS_HIGH = 3'h4;

  // Edge events stay masked until the synchroniser holds real samples
  localparam [1:0] SETTLE_LAST = `PSR_SYNC_SETTLE;

  // Rising edge from the current and previous synchronised sample
  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev; // RQ16
    end
  endfunction

  // Falling edge from the current and previous synchronised sample
  function fall_of;
    input cur;
    input prev;
    begin
      fall_of = ~cur & prev; // RQ16
    end
  endfunction

  // Which stop causes rearm the interlock in each mode
  function rearm_of;
    input [1:0] mode;
    input start_f;
    input stroke_r;
    input perm1_f;
    begin
      case (mode)
        `PSR_MODE_NONE: begin
          rearm_of = 1'b0; // RQ8
        end
        `PSR_MODE_ALWAYS: begin
          rearm_of = start_f | stroke_r | perm1_f; // RQ12
        end
        `PSR_MODE_START: begin
          rearm_of = start_f | perm1_f; // RQ13
        end
        `PSR_MODE_STROKE: begin
          rearm_of = stroke_r | perm1_f; // RQ14
        end
        default: begin
          rearm_of = 1'b0;
        end
      endcase
    end
  endfunction

  // Every mode but step operation keeps an interlock
  function locking_mode;
    input [1:0] mode;
    begin
      locking_mode = (mode != `PSR_MODE_NONE); // RQ8
    end
  endfunction

  // Two-stage synchronisers for the pin inputs; only sync_ff reads meta_ff
  reg [NPINS-1:0] meta_ff;
  reg [NPINS-1:0] sync_ff;
  reg [NPINS-1:0] prev_ff;
  wire [NPINS-1:0] pins;
  assign pins = {i_restart, i_stroke_end, i_permit2, i_permit1, i_start};
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= 5'h00;
      sync_ff <= 5'h00;
      prev_ff <= 5'h00;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Settle counter after reset; stops at its last value
  reg [1:0] settle_ff;
  always @(posedge i_clk) begin
    if (i_rst) begin
      settle_ff <= 2'h0;
    end else if (settle_ff != SETTLE_LAST) begin
      settle_ff <= settle_ff + 2'h1;
    end
  end
  // Hides the false edge that the reset value of prev_ff would make
  // against a pin already high, e.g. a start held through power up
  wire settled = (settle_ff == SETTLE_LAST);

  // Synchronised pin levels
  wire start_s = sync_ff[PIN_START];
  wire perm1_s = sync_ff[PIN_PERM1];
  wire perm2_s = sync_ff[PIN_PERM2];
  wire stroke_s = sync_ff[PIN_STROKE];
  wire rst_in_s = sync_ff[PIN_RESTART];

  // Edge events, one cycle each
  wire start_rise = settled & rise_of(start_s, prev_ff[PIN_START]); // RQ16
  wire start_fall = settled & fall_of(start_s, prev_ff[PIN_START]); // RQ16
  wire perm1_fall = settled & fall_of(perm1_s, prev_ff[PIN_PERM1]); // RQ16
  // Stroke end has no effect at all while single stroke is off
  wire stroke_rise = settled & i_stroke_en & rise_of(stroke_s, prev_ff[PIN_STROKE]); // RQ10
  wire restart_rise = settled & rise_of(rst_in_s, prev_ff[PIN_RESTART]); // RQ16

  // Millisecond enable from the divider
  wire tick;
  psr_ms_tick #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  // Minimum restart pulse width chosen by configuration
  wire [PULSE_W-1:0] min_ms = i_long_pulse ? 9'd`PSR_MIN_PULSE_LONG_MS : 9'd`PSR_MIN_PULSE_SHORT_MS;

  // Restart sequence state and pulse width in milliseconds
  reg [2:0] rs_state_ff;
  reg [2:0] nxt_rs_state;
  reg [PULSE_W-1:0] pulse_ms_ff;
  reg [PULSE_W-1:0] nxt_pulse_ms;
  reg restart_ok;
  always @(posedge i_clk) begin
    if (i_rst) begin
      rs_state_ff <= RS_WAIT_LOW;
      pulse_ms_ff <= PULSE_ZERO;
    end else begin
      rs_state_ff <= nxt_rs_state;
      pulse_ms_ff <= nxt_pulse_ms;
    end
  end

  // Low, high for the minimum, low again; anything else is ignored
  // Tick phase makes the measured width up to 1 ms short or nearly 1 ms long
  always @* begin
    nxt_rs_state = rs_state_ff;
    nxt_pulse_ms = pulse_ms_ff;
    restart_ok = 1'b0;
    case (rs_state_ff)
      RS_WAIT_LOW: begin
        if (settled && !rst_in_s) begin
          nxt_rs_state = RS_LOW;
        end
      end
      RS_LOW: begin
        if (restart_rise) begin
          nxt_rs_state = RS_HIGH;
          nxt_pulse_ms = PULSE_ZERO;
        end
      end
      RS_HIGH: begin
        if (!rst_in_s) begin
          nxt_rs_state = RS_LOW;
          restart_ok = (pulse_ms_ff >= min_ms); // RQ11
        end else if (tick && pulse_ms_ff != PULSE_MAX) begin
          nxt_pulse_ms = pulse_ms_ff + PULSE_ONE; // RQ15
        end
      end
      default: begin
        nxt_rs_state = RS_WAIT_LOW;
      end
    endcase
  end

  // Interlock rearm by stop cause and mode
  wire rearm = rearm_of(i_mode, start_fall, stroke_rise, perm1_fall);

  // Interlock flag; power up interlocked unless step mode
  // A rearming stop in the same cycle as a valid restart wins: stay locked
  reg lock_ff;
  reg init_ff;
  always @(posedge i_clk) begin
    if (i_rst) begin
      lock_ff <= 1'b0;
      init_ff <= 1'b1;
    end else begin
      init_ff <= 1'b0;
      if (!locking_mode(i_mode)) begin
        lock_ff <= 1'b0;
      end else if (init_ff || rearm) begin
        lock_ff <= 1'b1; // RQ6
      end else if (restart_ok) begin
        lock_ff <= 1'b0; // RQ7
      end
    end
  end

  // Second permit only matters while waiting to start
  wire perm2_ok = ~i_permit2_en | perm2_s; // RQ9
  // Any stop cause, including a pending interlock
  wire stop = ~perm1_s | start_fall | stroke_rise | lock_ff; // RQ1 RQ3 RQ5 RQ15

  // Release state register
  reg [1:0] rel_state_ff;
  reg [1:0] nxt_rel_state;
  always @(posedge i_clk) begin
    if (i_rst) begin
      rel_state_ff <= REL_IDLE;
    end else begin
      rel_state_ff <= nxt_rel_state;
    end
  end

  // Start edge moves to run; any stop returns to idle
  // Once running the second permit is no longer looked at
  always @* begin
    nxt_rel_state = rel_state_ff;
    case (rel_state_ff)
      REL_IDLE: begin
        if (!stop && start_rise && perm2_ok) begin
          nxt_rel_state = REL_RUN; // RQ3 RQ4
        end
      end
      REL_RUN: begin
        if (stop) begin
          nxt_rel_state = REL_IDLE; // RQ3 RQ5
        end
      end
      default: begin
        nxt_rel_state = REL_IDLE;
      end
    endcase
  end
  wire running = rel_state_ff[1];

  // Outputs registered; release also gated by the synced permit
  // The stop term is combinational so a drop costs no extra cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_release <= 1'b0;
      o_restart_req <= 1'b0;
      o_permit1_n <= 1'b1;
    end else begin
      o_release <= running & perm1_s & ~stop; // RQ1
      o_restart_req <= lock_ff & locking_mode(i_mode); // RQ6
      o_permit1_n <= ~perm1_s; // RQ2
    end
  end
endmodule // psr_top
`default_nettype wire
